// ### ddrw_pkg.sv
// Shared constants, types and state codes for the DDR SRAM write-port byte-lane masking block.
package ddrw_pkg;

  // Data path geometry: up to four nine-bit byte lanes.
  localparam int LANE_W = 9;
  localparam int LANES  = 4;
  localparam int DATA_W = LANE_W * LANES;

  // Modelled array depth; the location index addresses a pair of burst words.
  localparam int ADDR_W = 4;
  localparam int IDX_W  = ADDR_W + 1;
  localparam int WORDS  = 2 ** IDX_W;

  // Organisation strap codes.
  localparam logic [1:0] ORG_X9  = 2'h0;
  localparam logic [1:0] ORG_X18 = 2'h1;
  localparam logic [1:0] ORG_X36 = 2'h2;

  // Lane select patterns, active low.
  localparam logic [LANES-1:0] SEL_NONE = 4'hF;
  localparam logic [LANES-1:0] SEL_ALL  = 4'h0;

  // Burst word positions inside a location.
  localparam logic WORD_FIRST  = 1'h0;
  localparam logic WORD_SECOND = 1'h1;

  // Pins from the memory controller, sampled together.
  typedef struct packed {
    logic              k;
    logic              k_b;
    logic              c;
    logic              c_b;
    logic              write_port_select_n;
    logic              read_port_select_n;
    logic [LANES-1:0]  byte_lane_write_select_n;
    logic [1:0]        org;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] d;
  } ddrw_pins_t;

  // One captured write burst: base location and two words with lane selects.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] d0;
    logic [LANES-1:0]  sel0_n;
    logic [DATA_W-1:0] d1;
    logic [LANES-1:0]  sel1_n;
  } ddrw_burst_t;

  typedef enum logic [2:0] {
    W_IDLE    = 3'h1,
    W_WAIT_KB = 3'h2,
    W_HOLD    = 3'h4
  } ddrw_wr_state_t;

  typedef enum logic [2:0] {
    D_IDLE  = 3'h1,
    D_WORD0 = 3'h2,
    D_WORD1 = 3'h4
  } ddrw_drain_state_t;

  typedef enum logic [4:0] {
    R_IDLE     = 5'h01,
    R_WAIT_K   = 5'h02,
    R_WAIT_CB  = 5'h04,
    R_WAIT_C   = 5'h08,
    R_WAIT_END = 5'h10
  } ddrw_rd_state_t;

endpackage

// ### ddrw_lane_merge.sv
// One byte lane of the write merge: new data where selected, old contents otherwise.
`timescale 1ns/100ps
module ddrw_lane_merge #(
  parameter int W = 9
) (
  input  wire logic [W-1:0] old_data,
  input  wire logic [W-1:0] new_data,
  input  wire logic         sel_n,
  output logic [W-1:0]      merged
);

  // A deselected lane passes the stored bits back unchanged.
  assign merged = sel_n ? old_data : new_data;

endmodule

// ### ddrw_pair_buf.sv
// Two-entry first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/100ps
module ddrw_pair_buf #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  logic [W-1:0] slot_reg [0:1];
  logic         wr_ptr_reg;
  logic         rd_ptr_reg;
  logic [1:0]   count_reg;
  logic         push;
  logic         pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready  = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data  = slot_reg[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Slot storage is written only on a push.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slot_reg[0] <= '0;
      slot_reg[1] <= '0;
    end else if (push) begin
      slot_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and count; a push and pop together keep the count.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= 1'h0;
      rd_ptr_reg <= 1'h0;
      count_reg  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 2'h1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 2'h1;
      end
    end
  end

endmodule

// ### ddrw_write_port.sv
// DDR SRAM write port with byte-lane masking, a small read port and the storage array.
`timescale 1ns/100ps
module ddrw_write_port (
  input  wire logic                          CLK_SYS,
  input  wire logic                          RST_B,
  input  wire logic                          K,
  input  wire logic                          K_B,
  input  wire logic                          C,
  input  wire logic                          C_B,
  input  wire logic [1:0]                    ORG_SEL,
  input  wire logic                          WRITE_PORT_SELECT_N,
  input  wire logic                          READ_PORT_SELECT_N,
  input  wire logic [ddrw_pkg::LANES-1:0]    BYTE_LANE_WRITE_SELECT_N,
  input  wire logic [ddrw_pkg::ADDR_W-1:0]   ADDR,
  input  wire logic [ddrw_pkg::DATA_W-1:0]   D,
  output logic      [ddrw_pkg::DATA_W-1:0]   Q,
  output logic                               Q_OE_B,
  output logic                               WRITE_BUSY
);

  ddrw_pkg::ddrw_pins_t        pins_raw;
  ddrw_pkg::ddrw_pins_t        pins_s1_reg;
  ddrw_pkg::ddrw_pins_t        pins_s2_reg;
  logic [3:0]                  clk_prev_reg;
  logic                        k_rise;
  logic                        kb_rise;
  logic                        c_rise;
  logic                        cb_rise;
  logic                        oref_rise;
  logic                        oref_b_rise;
  logic                        strap_done_reg;
  logic [1:0]                  strap_fill_reg;
  logic [3:0]                  strap_prev_reg;
  logic [1:0]                  org_reg;
  logic                        single_clk_reg;
  ddrw_pkg::ddrw_wr_state_t    w_state_reg;
  ddrw_pkg::ddrw_burst_t       burst_reg;
  logic                        buf_in_valid;
  logic                        buf_in_ready;
  ddrw_pkg::ddrw_burst_t       buf_out;
  logic                        buf_out_valid;
  logic                        buf_out_ready;
  ddrw_pkg::ddrw_drain_state_t d_state_reg;
  ddrw_pkg::ddrw_burst_t       cur_reg;
  logic [ddrw_pkg::DATA_W-1:0] mem_reg [0:ddrw_pkg::WORDS-1];
  logic [ddrw_pkg::IDX_W-1:0]  wr_idx;
  logic [ddrw_pkg::DATA_W-1:0] wr_data;
  logic [ddrw_pkg::LANES-1:0]  wr_sel_n;
  logic [ddrw_pkg::DATA_W-1:0] merged;
  logic                        wr_en;
  ddrw_pkg::ddrw_rd_state_t    r_state_reg;
  logic [ddrw_pkg::ADDR_W-1:0] raddr_reg;
  logic [ddrw_pkg::DATA_W-1:0] q0_reg;
  logic [ddrw_pkg::DATA_W-1:0] q1_reg;
  logic                        read_fetch;

  // Lane selects valid for the strapped organisation; unused lanes read as deselected.
  function automatic logic [ddrw_pkg::LANES-1:0] org_sel_n(
    input logic [1:0]                 org,
    input logic [ddrw_pkg::LANES-1:0] sel_n
  );
    logic [ddrw_pkg::LANES-1:0] res;
    res = ddrw_pkg::SEL_NONE;
    if (org == ddrw_pkg::ORG_X9) begin
      res[0] = sel_n[0];
    end else if (org == ddrw_pkg::ORG_X18) begin
      res[1:0] = sel_n[1:0];
    end else begin
      res = sel_n;
    end
    return res;
  endfunction

  // Bits of the data bus that exist in the strapped organisation.
  function automatic logic [ddrw_pkg::DATA_W-1:0] org_bits(input logic [1:0] org);
    logic [ddrw_pkg::DATA_W-1:0] res;
    res = '0;
    for (int i = 0; i < ddrw_pkg::LANES; i++) begin
      if (org_sel_n(org, ddrw_pkg::SEL_NONE ^ (ddrw_pkg::SEL_ALL | (4'h1 << i)))
          != ddrw_pkg::SEL_NONE) begin
        res[i*ddrw_pkg::LANE_W +: ddrw_pkg::LANE_W] = '1;
      end
    end
    return res;
  endfunction

  // Every pin crosses two flip-flops; the controller holds data steady around its edges.
  assign pins_raw = '{k: K, k_b: K_B, c: C, c_b: C_B,
                      write_port_select_n: WRITE_PORT_SELECT_N,
                      read_port_select_n: READ_PORT_SELECT_N,
                      byte_lane_write_select_n: BYTE_LANE_WRITE_SELECT_N,
                      org: ORG_SEL, addr: ADDR, d: D};

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      pins_s1_reg <= '0;
      pins_s2_reg <= '0;
    end else begin
      pins_s1_reg <= pins_raw;
      pins_s2_reg <= pins_s1_reg;
    end
  end

  // Previous clock levels for rising-edge detection, taken from the second stage only.
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      clk_prev_reg <= 4'h0;
    end else begin
      clk_prev_reg <= {pins_s2_reg.k, pins_s2_reg.k_b, pins_s2_reg.c, pins_s2_reg.c_b};
    end
  end

  assign k_rise  = pins_s2_reg.k && !clk_prev_reg[3];
  assign kb_rise = pins_s2_reg.k_b && !clk_prev_reg[2];
  assign c_rise  = pins_s2_reg.c && !clk_prev_reg[1];
  assign cb_rise = pins_s2_reg.c_b && !clk_prev_reg[0];

  // In single-clock mode the input pair stands in for the output pair.
  assign oref_rise   = single_clk_reg ? k_rise : c_rise;
  assign oref_b_rise = single_clk_reg ? kb_rise : cb_rise;

  // Straps are caught once the second stage has filled and held still for one edge.
  // Comparing against a copy of the second stage keeps the first stage private.
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      strap_fill_reg <= 2'h0;
      strap_prev_reg <= 4'h0;
      strap_done_reg <= 1'h0;
      org_reg        <= ddrw_pkg::ORG_X36;
      single_clk_reg <= 1'h0;
    end else begin
      strap_fill_reg <= {strap_fill_reg[0], 1'h1};
      strap_prev_reg <= {pins_s2_reg.org, pins_s2_reg.c, pins_s2_reg.c_b};
      if (!strap_done_reg && strap_fill_reg[1]
          && (strap_prev_reg == {pins_s2_reg.org, pins_s2_reg.c, pins_s2_reg.c_b})) begin
        strap_done_reg <= 1'h1;
        org_reg        <= pins_s2_reg.org;
        single_clk_reg <= pins_s2_reg.c && pins_s2_reg.c_b;
      end
    end
  end

  // Write capture: first word at the true rise, second word and address at the complement rise.
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      w_state_reg <= ddrw_pkg::W_IDLE;
      burst_reg   <= '0;
    end else begin
      case (w_state_reg)
        ddrw_pkg::W_IDLE: begin
          if (strap_done_reg && k_rise && !pins_s2_reg.write_port_select_n) begin
            burst_reg.d0     <= pins_s2_reg.d;
            burst_reg.sel0_n <= org_sel_n(org_reg, pins_s2_reg.byte_lane_write_select_n);
            w_state_reg      <= ddrw_pkg::W_WAIT_KB;
          end
        end
        ddrw_pkg::W_WAIT_KB: begin
          if (kb_rise) begin
            burst_reg.addr   <= pins_s2_reg.addr;
            burst_reg.d1     <= pins_s2_reg.d;
            // The second word's selects are sampled afresh, not reused.
            burst_reg.sel1_n <= org_sel_n(org_reg, pins_s2_reg.byte_lane_write_select_n);
            w_state_reg      <= ddrw_pkg::W_HOLD;
          end
        end
        ddrw_pkg::W_HOLD: begin
          if (buf_in_ready) begin
            w_state_reg <= ddrw_pkg::W_IDLE;
          end
        end
        default: begin
          w_state_reg <= ddrw_pkg::W_IDLE;
        end
      endcase
    end
  end

  // A full buffer holds the capture stage; a true rise meanwhile is not taken.
  assign buf_in_valid = (w_state_reg == ddrw_pkg::W_HOLD);

  ddrw_pair_buf #(
    .W ($bits(ddrw_pkg::ddrw_burst_t))
  ) u_burst_buf (
    .clk       (CLK_SYS),
    .rst_b     (RST_B),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (burst_reg),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out)
  );

  // The array read for a read fetch wins the cycle; the drain waits for it.
  assign read_fetch    = (r_state_reg == ddrw_pkg::R_WAIT_K) && k_rise;
  assign buf_out_ready = (d_state_reg == ddrw_pkg::D_IDLE) && !read_fetch;

  // Drain: base location first, the next sequential location second.
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      d_state_reg <= ddrw_pkg::D_IDLE;
      cur_reg     <= '0;
    end else begin
      case (d_state_reg)
        ddrw_pkg::D_IDLE: begin
          if (buf_out_valid && buf_out_ready) begin
            cur_reg     <= buf_out;
            d_state_reg <= ddrw_pkg::D_WORD0;
          end
        end
        ddrw_pkg::D_WORD0: begin
          d_state_reg <= ddrw_pkg::D_WORD1;
        end
        ddrw_pkg::D_WORD1: begin
          d_state_reg <= ddrw_pkg::D_IDLE;
        end
        default: begin
          d_state_reg <= ddrw_pkg::D_IDLE;
        end
      endcase
    end
  end

  // Word steering for the current drain step.
  always_comb begin
    wr_idx   = {cur_reg.addr, ddrw_pkg::WORD_FIRST};
    wr_data  = cur_reg.d0;
    wr_sel_n = cur_reg.sel0_n;
    if (d_state_reg == ddrw_pkg::D_WORD1) begin
      wr_idx   = {cur_reg.addr, ddrw_pkg::WORD_SECOND};
      wr_data  = cur_reg.d1;
      wr_sel_n = cur_reg.sel1_n;
    end
  end

  // A word with every lane deselected never touches the array.
  assign wr_en = ((d_state_reg == ddrw_pkg::D_WORD0) || (d_state_reg == ddrw_pkg::D_WORD1))
                 && (wr_sel_n != ddrw_pkg::SEL_NONE);

  // Per-lane merge against the stored word, so masking costs no extra external cycle.
  for (genvar i = 0; i < ddrw_pkg::LANES; i++) begin : g_lane
    ddrw_lane_merge #(
      .W (ddrw_pkg::LANE_W)
    ) u_merge (
      .old_data (mem_reg[wr_idx][i*ddrw_pkg::LANE_W +: ddrw_pkg::LANE_W]),
      .new_data (wr_data[i*ddrw_pkg::LANE_W +: ddrw_pkg::LANE_W]),
      .sel_n    (wr_sel_n[i]),
      .merged   (merged[i*ddrw_pkg::LANE_W +: ddrw_pkg::LANE_W])
    );
  end

  // Storage array in flip-flops.
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      for (int j = 0; j < ddrw_pkg::WORDS; j++) begin
        mem_reg[j] <= '0;
      end
    end else if (wr_en) begin
      mem_reg[wr_idx] <= merged;
    end
  end

  // Read port: latch at a true rise, fetch at the next, launch on the output clock pair, or on the input pair in single-clock mode.
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      r_state_reg <= ddrw_pkg::R_IDLE;
      raddr_reg   <= '0;
      q0_reg      <= '0;
      q1_reg      <= '0;
      Q           <= '0;
      Q_OE_B      <= 1'h1;
    end else begin
      case (r_state_reg)
        ddrw_pkg::R_IDLE: begin
          if (strap_done_reg && k_rise && !pins_s2_reg.read_port_select_n) begin
            raddr_reg   <= pins_s2_reg.addr;
            r_state_reg <= ddrw_pkg::R_WAIT_K;
          end
        end
        ddrw_pkg::R_WAIT_K: begin
          if (k_rise) begin
            q0_reg      <= mem_reg[{raddr_reg, ddrw_pkg::WORD_FIRST}] & org_bits(org_reg);
            q1_reg      <= mem_reg[{raddr_reg, ddrw_pkg::WORD_SECOND}] & org_bits(org_reg);
            r_state_reg <= ddrw_pkg::R_WAIT_CB;
          end
        end
        ddrw_pkg::R_WAIT_CB: begin
          if (oref_b_rise) begin
            Q           <= q0_reg;
            Q_OE_B      <= 1'h0;
            r_state_reg <= ddrw_pkg::R_WAIT_C;
          end
        end
        ddrw_pkg::R_WAIT_C: begin
          if (oref_rise) begin
            Q           <= q1_reg;
            r_state_reg <= ddrw_pkg::R_WAIT_END;
          end
        end
        ddrw_pkg::R_WAIT_END: begin
          if (oref_b_rise) begin
            Q_OE_B      <= 1'h1;
            r_state_reg <= ddrw_pkg::R_IDLE;
          end
        end
        default: begin
          r_state_reg <= ddrw_pkg::R_IDLE;
        end
      endcase
    end
  end

  // Busy while any burst is held, buffered or being written.
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      WRITE_BUSY <= 1'h0;
    end else begin
      WRITE_BUSY <= (w_state_reg != ddrw_pkg::W_IDLE) || buf_out_valid
                    || (d_state_reg != ddrw_pkg::D_IDLE);
    end
  end

  // Checking helpers: the last array write and the bits it had to keep.
  logic                        hlp_valid_reg;
  logic [ddrw_pkg::IDX_W-1:0]  hlp_idx_reg;
  logic [ddrw_pkg::DATA_W-1:0] hlp_old_reg;
  logic [ddrw_pkg::DATA_W-1:0] hlp_new_reg;
  logic [ddrw_pkg::LANES-1:0]  hlp_sel_reg;
  logic [ddrw_pkg::DATA_W-1:0] hlp_keep;

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      hlp_valid_reg <= 1'h0;
      hlp_idx_reg   <= '0;
      hlp_old_reg   <= '0;
      hlp_new_reg   <= '0;
      hlp_sel_reg   <= ddrw_pkg::SEL_NONE;
    end else begin
      hlp_valid_reg <= wr_en;
      hlp_idx_reg   <= wr_idx;
      hlp_old_reg   <= mem_reg[wr_idx];
      hlp_new_reg   <= wr_data;
      hlp_sel_reg   <= wr_sel_n;
    end
  end

  always_comb begin
    hlp_keep = '0;
    for (int i = 0; i < ddrw_pkg::LANES; i++) begin
      hlp_keep[i*ddrw_pkg::LANE_W +: ddrw_pkg::LANE_W] = {ddrw_pkg::LANE_W{hlp_sel_reg[i]}};
    end
  end

  default clocking cb_sys @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  sequence s_word0_step;
    d_state_reg == ddrw_pkg::D_WORD0;
  endsequence

  sequence s_word1_step;
    d_state_reg == ddrw_pkg::D_WORD1;
  endsequence

  sequence s_launch_first;
    (r_state_reg == ddrw_pkg::R_WAIT_CB) && oref_b_rise;
  endsequence

  a_full_word_store: assert property (
    hlp_valid_reg && (hlp_sel_reg == ddrw_pkg::SEL_ALL) |-> mem_reg[hlp_idx_reg] == hlp_new_reg)
    else $error("Fully selected word not stored whole.");

  a_lane_zero_store: assert property (
    hlp_valid_reg && !hlp_sel_reg[0] |-> mem_reg[hlp_idx_reg][8:0] == hlp_new_reg[8:0])
    else $error("Lane zero data not stored.");

  a_lane_one_store: assert property (
    hlp_valid_reg && !hlp_sel_reg[1] |-> mem_reg[hlp_idx_reg][17:9] == hlp_new_reg[17:9])
    else $error("Lane one data not stored.");

  a_lane_two_store: assert property (
    hlp_valid_reg && !hlp_sel_reg[2] |-> mem_reg[hlp_idx_reg][26:18] == hlp_new_reg[26:18])
    else $error("Lane two data not stored.");

  a_lane_three_store: assert property (
    hlp_valid_reg && !hlp_sel_reg[3] |-> mem_reg[hlp_idx_reg][35:27] == hlp_new_reg[35:27])
    else $error("Lane three data not stored.");

  a_masked_lane_keep: assert property (
    hlp_valid_reg |-> ((mem_reg[hlp_idx_reg] ^ hlp_old_reg) & hlp_keep) == '0)
    else $error("Deselected lane changed in the array.");

  a_no_select_idle: assert property (
    s_word0_step ##0 (cur_reg.sel0_n == ddrw_pkg::SEL_NONE) |-> !wr_en)
    else $error("Array written with every lane deselected.");

  a_narrow_org_mask: assert property (
    (org_reg == ddrw_pkg::ORG_X9) && wr_en |-> wr_sel_n[3:1] == 3'h7)
    else $error("Upper lanes selected in nine-bit organisation.");

  a_burst_order_seq: assert property (
    s_word0_step |=> s_word1_step ##0 (wr_idx == {$past(wr_idx[ddrw_pkg::IDX_W-1:1]), 1'h1}))
    else $error("Second burst word not at next location.");

  a_capture_on_rise: assert property (
    (w_state_reg == ddrw_pkg::W_WAIT_KB) && kb_rise |=> w_state_reg == ddrw_pkg::W_HOLD
      && burst_reg.d1 == $past(pins_s2_reg.d))
    else $error("Second word not captured on complement rise.");

  a_read_launch_pair: assert property (
    s_launch_first |=> !Q_OE_B && (Q == q0_reg) ##0 (r_state_reg == ddrw_pkg::R_WAIT_C))
    else $error("First read word not launched on output clock.");

  a_idle_tristate: assert property (
    (r_state_reg == ddrw_pkg::R_IDLE) || (r_state_reg == ddrw_pkg::R_WAIT_K) |-> Q_OE_B)
    else $error("Read outputs driven while deselected.");

endmodule

// ### ddrw_ctrl_model.sv
// Behavioural memory controller that drives the write and read ports of the SRAM block.
`timescale 1ns/100ps
module ddrw_ctrl_model (
  input  wire logic                        clk,
  input  wire logic [ddrw_pkg::DATA_W-1:0] q,
  input  wire logic                        q_oe_b,
  output ddrw_pkg::ddrw_pins_t             pins
);
  // Clocks rest high between transfers, which allows the quickest restart.
  initial begin
    pins = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, ddrw_pkg::SEL_NONE, ddrw_pkg::ORG_X36,
             4'h0, 36'h0};
  end

  // With two_clk set, the output pair is strapped active and follows the input pair.
  logic dual = 1'b0;

  task automatic strap(input logic [1:0] o, input logic two_clk);
    pins.org <= o;
    pins.c <= !two_clk;
    dual = two_clk;
  endtask

  // One input clock pulse; five cycles low and six high cover the block's synchronisers.
  task automatic pulse(input logic comp);
    @(posedge clk);
    if (comp) begin
      pins.k_b <= 1'b0;
      if (dual) pins.c_b <= 1'b0;
    end else begin
      pins.k <= 1'b0;
      if (dual) pins.c <= 1'b0;
    end
    repeat (5) @(posedge clk);
    if (comp) begin
      pins.k_b <= 1'b1;
      if (dual) pins.c_b <= 1'b1;
    end else begin
      pins.k <= 1'b1;
      if (dual) pins.c <= 1'b1;
    end
    repeat (6) @(posedge clk);
  endtask

  task automatic write_burst(input logic [3:0] a, input logic [35:0] d0,
      input logic [3:0] s0, input logic [35:0] d1, input logic [3:0] s1);
    @(posedge clk);
    pins.write_port_select_n <= 1'b0;
    pins.d <= d0;
    pins.byte_lane_write_select_n <= s0;
    pulse(1'b0);
    pins.write_port_select_n <= 1'b1;
    pins.addr <= a;
    pins.d <= d1;
    pins.byte_lane_write_select_n <= s1;
    pulse(1'b1);
    // Released data shows the inverse, so a late capture cannot pass by luck.
    pins.d <= ~d1;
    pins.byte_lane_write_select_n <= ~s1;
  endtask

  // Single-clock mode: the input pair also paces the output words.
  task automatic read_burst(input logic [3:0] a, output logic [35:0] q0,
      output logic [35:0] q1, output logic on, output logic off);
    @(posedge clk);
    pins.read_port_select_n <= 1'b0;
    pins.addr <= a;
    pulse(1'b0);
    pins.read_port_select_n <= 1'b1;
    pins.addr <= ~a;
    pulse(1'b1);
    pulse(1'b0);
    pulse(1'b1);
    q0 = q;
    on = q_oe_b;
    pulse(1'b0);
    q1 = q;
    pulse(1'b1);
    off = q_oe_b;
  endtask
endmodule

// ### ddr_sram_byte_write_mask_tb.sv
// Self-checking testbench for the write port with byte-lane masking.
`timescale 1ns/100ps
`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin error_cnt++; \
  $display("wrong value %s expected %h seen %h", what, exp, got); end end
module ddr_sram_byte_write_mask_tb;
  logic                 CLK_SYS;
  logic                 RST_B;
  ddrw_pkg::ddrw_pins_t pins;
  logic [35:0]          q;
  logic                 q_oe_b;
  logic                 write_busy;
  logic [35:0]          exp_mem [32];
  logic [1:0]           org;
  int                   error_cnt;
  int                   n_tests;

  ddrw_ctrl_model ddrw_ctrl_model_i (.clk(CLK_SYS), .q(q), .q_oe_b(q_oe_b), .pins(pins));
  ddrw_write_port ddrw_write_port_i (
    .CLK_SYS(CLK_SYS), .RST_B(RST_B), .K(pins.k), .K_B(pins.k_b), .C(pins.c), .C_B(pins.c_b),
    .ORG_SEL(pins.org), .WRITE_PORT_SELECT_N(pins.write_port_select_n),
    .READ_PORT_SELECT_N(pins.read_port_select_n),
    .BYTE_LANE_WRITE_SELECT_N(pins.byte_lane_write_select_n), .ADDR(pins.addr), .D(pins.d),
    .Q(q), .Q_OE_B(q_oe_b), .WRITE_BUSY(write_busy));

  initial begin
    CLK_SYS = 1'b0;
    forever #20 CLK_SYS = ~CLK_SYS;
  end

  // Reset with a new strap, since the organisation is taken only once after reset.
  task automatic restart(input logic [1:0] o, input logic two_clk);
    org = o;
    ddrw_ctrl_model_i.strap(o, two_clk);
    @(posedge CLK_SYS);
    RST_B <= 1'b0;
    repeat (5) @(posedge CLK_SYS);
    RST_B <= 1'b1;
    foreach (exp_mem[i]) exp_mem[i] = 36'h0;
    `CHK("q after reset", 36'h0, q)
    `CHK("drive after reset", 1'b1, q_oe_b)
    repeat (6) @(posedge CLK_SYS);
  endtask

  // Lanes outside the organisation are never written, so they keep the reset zero.
  function automatic logic [35:0] merge(input logic [35:0] old_w, input logic [35:0] new_w,
      input logic [3:0] sel_n);
    logic [35:0] r;
    int          nl;
    r = old_w;
    nl = (org == ddrw_pkg::ORG_X9) ? 1 : (org == ddrw_pkg::ORG_X18) ? 2 : 4;
    for (int i = 0; i < nl; i++) begin
      if (!sel_n[i]) r[i*9 +: 9] = new_w[i*9 +: 9];
    end
    return r;
  endfunction

  task automatic wr(input logic [3:0] a, input logic [35:0] d0, input logic [3:0] s0,
      input logic [35:0] d1, input logic [3:0] s1);
    int n;
    ddrw_ctrl_model_i.write_burst(a, d0, s0, d1, s1);
    exp_mem[{a, 1'b0}] = merge(exp_mem[{a, 1'b0}], d0, s0);
    exp_mem[{a, 1'b1}] = merge(exp_mem[{a, 1'b1}], d1, s1);
    n = 0;
    while (write_busy !== 1'b0 && n < 40) begin
      @(posedge CLK_SYS);
      n++;
    end
    `CHK("write busy", 1'b0, write_busy)
  endtask

  task automatic rd(input logic [3:0] a);
    logic [35:0] q0;
    logic [35:0] q1;
    logic        on;
    logic        off;
    ddrw_ctrl_model_i.read_burst(a, q0, q1, on, off);
    `CHK("first word", exp_mem[{a, 1'b0}], q0)
    `CHK("second word", exp_mem[{a, 1'b1}], q1)
    `CHK("drive on", 1'b0, on)
    `CHK("drive off", 1'b1, off)
  endtask

  // Narrow selects carry stray low bits above the organisation on purpose.
  task automatic t_x18();
    restart(ddrw_pkg::ORG_X18, 1'b0);
    wr(4'h3, 36'hF_FFFF_FFFF, 4'h0, 36'hA_AAAA_AAAA, 4'h0);
    rd(4'h3);
    wr(4'h3, 36'h0_0000_0000, 4'hE, 36'h5_5555_5555, 4'hD);
    rd(4'h3);
    wr(4'h3, 36'h1_2345_6789, 4'h3, 36'h1_2345_6789, 4'hF);
    rd(4'h3);
    $display("test x18 done");
  endtask

  task automatic t_x9();
    restart(ddrw_pkg::ORG_X9, 1'b0);
    wr(4'h5, 36'hF_FFFF_FFFF, 4'hE, 36'hF_FFFF_FFFF, 4'h1);
    rd(4'h5);
    $display("test x9 done");
  endtask

  // The top location is filled, then each burst clears one lane in each of its two words, in turn.
  // This test runs with the output clock pair active, so reads launch on it.
  task automatic t_x36();
    restart(ddrw_pkg::ORG_X36, 1'b1);
    wr(4'hF, 36'hF_FFFF_FFFF, 4'h0, 36'hC_3C3C_3C3C, 4'h0);
    rd(4'hF);
    for (int i = 0; i < 4; i++) begin
      wr(4'hF, 36'h0, ~(4'h1 << i), 36'h0, ~(4'h8 >> i));
      rd(4'hF);
    end
    $display("test x36 done");
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // The tests need about one thousand cycles; the limit leaves a wide margin.
  initial begin
    repeat (30000) @(posedge CLK_SYS);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    RST_B = 1'b0;
    error_cnt = 0;
    n_tests = 0;
    t_x18();
    t_x9();
    t_x36();
    tally_and_finish();
  end
endmodule
